// file: pkg/aco_defines.vh
// Constants for the ATM cell octet port
`ifndef ACO_DEFINES_VH
`define ACO_DEFINES_VH
`define ACO_DATA_W        8
`define ACO_CELL_OCTETS   53
`define ACO_CNT_W         6
`define ACO_BUF_DEPTH     2
`define ACO_ST_IDLE       2'h0
`define ACO_ST_WAIT_EDGE  2'h1
`define ACO_ST_SEND       2'h2
`endif

// file: design/aco_skid_buf.v
// Two-entry valid/ready buffer
`timescale 1ns/1ps
module aco_skid_buf #(
  parameter W = 9
) (
  input  wire         clk,
  input  wire         rst_n,
  input  wire [W-1:0] in_data,
  input  wire         in_valid,
  output wire         in_ready,
  output wire [W-1:0] out_data,
  output wire         out_valid,
  input  wire         out_ready
);
  reg  [W-1:0] mem_reg [0:1];
  reg          wr_ptr_reg;
  reg          rd_ptr_reg;
  reg  [1:0]   count_reg;
  wire         push;
  wire         pop;

  assign in_ready  = (count_reg != 2'h2);
  assign out_valid = (count_reg != 2'h0);
  assign out_data  = mem_reg[rd_ptr_reg];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      count_reg  <= 2'h0;
      mem_reg[0] <= {W{1'b0}};
      mem_reg[1] <= {W{1'b0}};
    end else begin
      if (push) begin
        mem_reg[wr_ptr_reg] <= in_data;
        wr_ptr_reg          <= ~wr_ptr_reg;
      end
      if (pop)
        rd_ptr_reg <= ~rd_ptr_reg;
      if (push && !pop)
        count_reg <= count_reg + 2'h1;
      else if (pop && !push)
        count_reg <= count_reg - 2'h1;
    end
  end
endmodule // aco_skid_buf

// file: design/aco_cell_octet_port.v
// ATM-layer side of the byte-wide cell transfer port
// Overview of operation
// - Enabled port writes one tx octet per rising tx clock with enable low.
// - Tx cell start is high with the first octet of each cell.
// - Octets seen with rx enable high are discarded.
// - Disabled port tristates its transmit pins and its rx read enable.
`timescale 1ns/1ps
`include "aco_defines.vh"
module aco_cell_octet_port #(
  parameter DATA_W     = `ACO_DATA_W,
  parameter CELL_OCTETS = `ACO_CELL_OCTETS
) (
  input  wire              sys_clk,
  input  wire              rst_n,
  input  wire              port_enable,
  // Transmit user side: whole cells, first octet flagged
  input  wire [DATA_W-1:0] tx_data,
  input  wire              tx_first,
  input  wire              tx_valid,
  output wire              tx_ready,
  // Receive user side
  output wire [DATA_W-1:0] rx_data,
  output wire              rx_first,
  output wire              rx_valid,
  input  wire              rx_ready,
  output wire              rx_cell_waiting,
  // Transmit pins
  input  wire              tx_fifo_clock,
  output reg  [DATA_W-1:0] tx_octet_bus,
  output reg               tx_write_enable_n,
  output reg               tx_cell_start,
  output wire              tx_pins_oe,
  input  wire              tx_cell_space_flag,
  // Receive pins
  input  wire              rx_fifo_clock,
  input  wire [DATA_W-1:0] rx_octet_bus,
  input  wire              rx_cell_start,
  input  wire              rx_cell_ready_flag,
  output wire              rx_read_enable_n,
  output wire              rx_read_enable_oe
);
  // Two-flop synchronisers for every pin input
  reg              txc_s1_reg, txc_s2_reg, txc_s3_reg;
  reg              rxc_s1_reg, rxc_s2_reg, rxc_s3_reg;
  reg              tca_s1_reg, tca_s2_reg;
  reg              rca_s1_reg, rca_s2_reg;
  reg [DATA_W-1:0] rxd_s1_reg, rxd_s2_reg;
  reg              rsoc_s1_reg, rsoc_s2_reg;
  wire             tx_rise;
  wire             rx_rise;

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      txc_s1_reg  <= 1'b0;
      txc_s2_reg  <= 1'b0;
      txc_s3_reg  <= 1'b0;
      rxc_s1_reg  <= 1'b0;
      rxc_s2_reg  <= 1'b0;
      rxc_s3_reg  <= 1'b0;
      tca_s1_reg  <= 1'b0;
      tca_s2_reg  <= 1'b0;
      rca_s1_reg  <= 1'b0;
      rca_s2_reg  <= 1'b0;
      rxd_s1_reg  <= {DATA_W{1'b0}};
      rxd_s2_reg  <= {DATA_W{1'b0}};
      rsoc_s1_reg <= 1'b0;
      rsoc_s2_reg <= 1'b0;
    end else begin
      txc_s1_reg  <= tx_fifo_clock;
      txc_s2_reg  <= txc_s1_reg;
      txc_s3_reg  <= txc_s2_reg;
      rxc_s1_reg  <= rx_fifo_clock;
      rxc_s2_reg  <= rxc_s1_reg;
      rxc_s3_reg  <= rxc_s2_reg;
      tca_s1_reg  <= tx_cell_space_flag;
      tca_s2_reg  <= tca_s1_reg;
      rca_s1_reg  <= rx_cell_ready_flag;
      rca_s2_reg  <= rca_s1_reg;
      rxd_s1_reg  <= rx_octet_bus;
      rxd_s2_reg  <= rxd_s1_reg;
      rsoc_s1_reg <= rx_cell_start;
      rsoc_s2_reg <= rsoc_s1_reg;
    end
  end

  assign tx_rise = txc_s2_reg & ~txc_s3_reg;
  assign rx_rise = rxc_s2_reg & ~rxc_s3_reg;

  // ---------------- Transmit ----------------
  wire [DATA_W:0]  txb_data;
  wire             txb_valid;
  reg              txb_pop;
  reg  [1:0]       tx_state_reg;
  reg  [`ACO_CNT_W-1:0] tx_left_reg;

  aco_skid_buf #(.W(DATA_W + 1)) u_tx_buf (
    .clk       (sys_clk),
    .rst_n     (rst_n),
    .in_data   ({tx_first, tx_data}),
    .in_valid  (tx_valid & port_enable),
    .in_ready  (tx_ready),
    .out_data  (txb_data),
    .out_valid (txb_valid),
    .out_ready (txb_pop)
  );

  assign tx_pins_oe = port_enable;

  // Octets still owed after a cell's first one, cut to the counter width
  wire [31:0]           cell_octets_w;
  wire [`ACO_CNT_W-1:0] cell_rest;
  assign cell_octets_w = CELL_OCTETS;
  assign cell_rest     = cell_octets_w[`ACO_CNT_W-1:0] - {{(`ACO_CNT_W-1){1'b0}}, 1'b1};

  // Octets are put out on rising tx clock edges so the phy samples them
  // on its next rising edge, close to a full period of setup later.
  always @* begin
    txb_pop = 1'b0;
    if (port_enable && tx_rise && txb_valid) begin
      if (tx_state_reg == `ACO_ST_SEND)
        txb_pop = 1'b1;
      else if (tx_state_reg == `ACO_ST_IDLE && tca_s2_reg && txb_data[DATA_W])
        txb_pop = 1'b1;
    end
  end

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_state_reg      <= `ACO_ST_IDLE;
      tx_left_reg       <= {`ACO_CNT_W{1'b0}};
      tx_octet_bus      <= {DATA_W{1'b0}};
      tx_write_enable_n <= 1'b1;
      tx_cell_start     <= 1'b0;
    end else if (!port_enable) begin
      tx_state_reg      <= `ACO_ST_IDLE;
      tx_write_enable_n <= 1'b1;
      tx_cell_start     <= 1'b0;
    end else if (tx_rise) begin
      if (txb_pop) begin
        tx_octet_bus      <= txb_data[DATA_W-1:0];
        tx_write_enable_n <= 1'b0;
        tx_cell_start     <= (tx_state_reg == `ACO_ST_IDLE);
        if (tx_state_reg == `ACO_ST_IDLE) begin
          tx_left_reg  <= cell_rest;
          tx_state_reg <= `ACO_ST_SEND;
        end else begin
          tx_left_reg <= tx_left_reg - {{(`ACO_CNT_W-1){1'b0}}, 1'b1};
          if (tx_left_reg == {{(`ACO_CNT_W-1){1'b0}}, 1'b1})
            tx_state_reg <= `ACO_ST_IDLE;
        end
      end else begin
        tx_write_enable_n <= 1'b1;
        tx_cell_start     <= 1'b0;
        case (tx_state_reg)
          `ACO_ST_IDLE: tx_state_reg <= `ACO_ST_IDLE;
          `ACO_ST_SEND: tx_state_reg <= `ACO_ST_SEND;
          default:      tx_state_reg <= `ACO_ST_IDLE;
        endcase
      end
    end
  end

  // ---------------- Receive ----------------
  wire rxb_ready;
  reg  rx_en_n_reg;

  // Read enable is only asserted while the buffer has room for one octet
  // and the cell-ready flag is high; it changes on falling rx clock edges.
  wire rx_fall = ~rxc_s2_reg & rxc_s3_reg;
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n)
      rx_en_n_reg <= 1'b1;
    else if (!port_enable)
      rx_en_n_reg <= 1'b1;
    else if (rx_fall)
      rx_en_n_reg <= ~(rxb_ready & rca_s2_reg);
  end

  // Enable level seen by the phy at the last rising edge
  // Octet is taken two cycles after the rise, once every data bit has settled
  reg rx_en_seen_reg;
  reg rx_rise_d_reg;
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_en_seen_reg <= 1'b0;
      rx_rise_d_reg  <= 1'b0;
    end else begin
      rx_rise_d_reg <= rx_rise;
      if (rx_rise)
        rx_en_seen_reg <= ~rx_en_n_reg & port_enable;
    end
  end

  reg rx_take_reg;
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n)
      rx_take_reg <= 1'b0;
    else
      rx_take_reg <= rx_rise_d_reg & rx_en_seen_reg & port_enable;
  end

  assign rx_read_enable_n  = rx_en_n_reg;
  assign rx_read_enable_oe = port_enable;
  assign rx_cell_waiting   = rca_s2_reg & port_enable;

  aco_skid_buf #(.W(DATA_W + 1)) u_rx_buf (
    .clk       (sys_clk),
    .rst_n     (rst_n),
    .in_data   ({rsoc_s2_reg, rxd_s2_reg}),
    .in_valid  (rx_take_reg),
    .in_ready  (rxb_ready),
    .out_data  ({rx_first, rx_data}),
    .out_valid (rx_valid),
    .out_ready (rx_ready)
  );
endmodule // aco_cell_octet_port

// file: tb/aco_cell_octet_port_properties.sv
// Checker for the cell octet port pins
`timescale 1ns/1ps
module aco_cell_octet_port_properties (
  input logic sys_clk,
  input logic rst_n,
  input logic port_enable,
  input logic tx_write_enable_n,
  input logic tx_cell_start,
  input logic tx_pins_oe,
  input logic tx_cell_space_flag,
  input logic rx_read_enable_n,
  input logic rx_read_enable_oe,
  input logic rx_valid,
  input logic rx_cell_waiting
);
  logic [3:0] sp_age_reg;
  logic [3:0] rx_age_reg;
  // Cycles since space flag high / read enable low
  always @(posedge sys_clk or negedge rst_n)
    if (!rst_n) begin
      sp_age_reg <= 4'hf;
      rx_age_reg <= 4'hf;
    end else begin
      sp_age_reg <= tx_cell_space_flag ? 4'h0 : sp_age_reg + {3'h0, ~&sp_age_reg};
      rx_age_reg <= !rx_read_enable_n ? 4'h0 : rx_age_reg + {3'h0, ~&rx_age_reg};
    end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  sequence s_port_off;
    $fell(port_enable);
  endsequence
  sequence s_cell_open;
    $fell(tx_write_enable_n);
  endsequence
  a_oe_tracks_port: assert property (tx_pins_oe == port_enable && rx_read_enable_oe == port_enable)
    else $error("pin enables differ from port enable");
  a_wait_gated: assert property (!port_enable |-> !rx_cell_waiting)
    else $error("cell waiting while port disabled");
  a_write_needs_port: assert property (s_cell_open |-> port_enable)
    else $error("write while port disabled");
  a_disable_idles_tx: assert property (s_port_off |-> ##[1:4] tx_write_enable_n)
    else $error("tx not idle after disable");
  a_start_with_write: assert property (tx_cell_start |-> !tx_write_enable_n)
    else $error("cell start without write");
  a_open_has_start: assert property (s_cell_open |-> tx_cell_start)
    else $error("write opened without cell start");
  a_space_seen_first: assert property ($rose(tx_cell_start) |-> sp_age_reg < 4'h8)
    else $error("cell started without space");
  a_rx_after_read: assert property ($rose(rx_valid) |-> rx_age_reg < 4'hc)
    else $error("rx octet without read enable");
endmodule // aco_cell_octet_port_properties
bind aco_cell_octet_port aco_cell_octet_port_properties aco_props_i (.sys_clk, .rst_n,
  .port_enable, .tx_write_enable_n, .tx_cell_start, .tx_pins_oe, .tx_cell_space_flag,
  .rx_read_enable_n, .rx_read_enable_oe, .rx_valid, .rx_cell_waiting);

// file: tb/aco_phy_model.sv
// Far-side cell device model with tx and rx fifos
`timescale 1ns/1ps
module aco_phy_model (
  input  logic [7:0] tx_bus,
  input  logic       tx_wen_n,
  input  logic       tx_sop,
  input  logic       stall,
  input  logic       rx_ren_n,
  input  logic       flag_on,
  output logic       tx_clk,
  output logic       rx_clk,
  output logic       tx_space,
  output logic [7:0] rx_bus,
  output logic       rx_sop,
  output logic       rx_flag
);
  logic [8:0] got[$];
  int fill = 0;
  int idx = 0;
  initial tx_clk = 0;
  initial rx_clk = 0;
  always #32 tx_clk = ~tx_clk;
  initial #7 forever #32 rx_clk = ~rx_clk;
  // Fifo drains one octet per idle clock
  always @(posedge tx_clk)
    if (!tx_wen_n) begin
      got.push_back({tx_sop, tx_bus});
      fill <= fill + 1;
    end else if (fill > 0)
      fill <= fill - 1;
  assign tx_space = fill == 0 && !stall;
  // Octet goes out on the edge that sees the read enable; junk otherwise
  always @(posedge rx_clk)
    if (!rx_ren_n) begin
      rx_bus <= idx[7:0] ^ 8'h5a;
      rx_sop <= idx % 53 == 0;
      idx <= idx + 1;
    end else
      {rx_sop, rx_bus} <= 9'($random);
  assign rx_flag = flag_on;
endmodule // aco_phy_model

// file: tb/aco_cell_octet_port_tb.sv
// Self-checking bench for the cell octet port
`timescale 1ns/1ps
module aco_cell_octet_port_tb;
  logic sys_clk = 0, rst_n = 0, port_enable = 0, tx_first = 0, tx_valid = 0;
  logic rx_ready = 1, stall = 1, flag_on = 0;
  logic [7:0] tx_data = 8'h00;
  wire [7:0] tx_octet_bus, rx_data, rx_octet_bus;
  wire tx_ready, rx_first, rx_valid, rx_cell_waiting, tx_write_enable_n, tx_cell_start;
  wire tx_pins_oe, tx_cell_space_flag, tx_fifo_clock, rx_fifo_clock, rx_cell_start;
  wire rx_cell_ready_flag, rx_read_enable_n, rx_read_enable_oe;
  int mismatches = 0, n_tests = 0, nrx = 0, seed = 32'he8bb;
  logic [8:0] exp_q[$];
  always #2.5 sys_clk = ~sys_clk;
  aco_cell_octet_port aco_cell_octet_port_i (.sys_clk, .rst_n, .port_enable, .tx_data,
    .tx_first, .tx_valid, .tx_ready, .rx_data, .rx_first, .rx_valid, .rx_ready,
    .rx_cell_waiting, .tx_fifo_clock, .tx_octet_bus, .tx_write_enable_n, .tx_cell_start,
    .tx_pins_oe, .tx_cell_space_flag, .rx_fifo_clock, .rx_octet_bus, .rx_cell_start,
    .rx_cell_ready_flag, .rx_read_enable_n, .rx_read_enable_oe);
  aco_phy_model aco_phy_model_i (.tx_bus(tx_octet_bus), .tx_sop(tx_cell_start),
    .tx_wen_n(tx_pins_oe ? tx_write_enable_n : 1'b1), .stall(stall), .flag_on(flag_on),
    .rx_ren_n(rx_read_enable_oe ? rx_read_enable_n : 1'b1), .tx_clk(tx_fifo_clock),
    .rx_clk(rx_fifo_clock), .tx_space(tx_cell_space_flag), .rx_bus(rx_octet_bus),
    .rx_sop(rx_cell_start), .rx_flag(rx_cell_ready_flag));
  task automatic check(string name, logic [8:0] seen, logic [8:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic send(logic [7:0] d, logic f);
    @(negedge sys_clk);
    tx_data = d;
    tx_first = f;
    tx_valid = 1;
    exp_q.push_back({f, d});
    while (tx_ready !== 1'b1) @(negedge sys_clk);
    @(posedge sys_clk);
  endtask
  function automatic logic [8:0] exp_rx(int k);
    return {k % 53 == 0, k[7:0] ^ 8'h5a};
  endfunction
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Receive monitor with a randomly stalling user
  always @(negedge sys_clk) begin
    rx_ready = $random(seed) % 4 != 0;
    if (rx_valid === 1'b1 && rx_ready) begin
      check("rx octet", {rx_first, rx_data}, exp_rx(nrx));
      nrx++;
    end
  end
  initial begin
    repeat (2) @(negedge sys_clk);
    rst_n = 1;
    port_enable = 1;
    flag_on = 1;
    fork
      for (int c = 0; c < 2; c++)
        for (int i = 0; i < 53; i++) send(8'($random(seed)), i == 0);
      begin
        repeat (300) @(negedge sys_clk);
        check("held writes", 9'(aco_phy_model_i.got.size()), 9'h0);
        stall = 0;
      end
    join
    @(negedge sys_clk);
    tx_valid = 0;
    for (int t = 0; t < 3000 && aco_phy_model_i.got.size() < 106; t++) @(negedge sys_clk);
    foreach (exp_q[i]) check("tx octet", aco_phy_model_i.got[i], exp_q[i]);
    check("rx count", 9'(nrx > 20), 9'h1);
    $display("cell transfer test done");
    port_enable = 0;
    repeat (6) @(negedge sys_clk);
    check("released", {tx_pins_oe, rx_read_enable_oe, rx_cell_waiting, tx_write_enable_n}, 9'h1);
    $display("disable test done");
    close_out;
  end
  initial begin
    #100000;
    mismatches++;
    close_out;
  end
endmodule // aco_cell_octet_port_tb
